// ===== common/asc_pkg.sv
// Package for the activity shutdown controller: constants and carrier structs.
package asc_pkg;
  // Inactivity end-of-count in crystal cycles
  localparam int unsigned ASC_EOC_CYCLES = 65536;
  localparam int unsigned ASC_CNT_W = 17;
  // Buffered clock output divides the crystal by this ratio
  localparam int unsigned ASC_CLK_DIV = 16;
  localparam int unsigned ASC_DIV_W = 4;
  // Oscillator and PLL start-up interval
  localparam int unsigned ASC_CLK_PERIOD_NS = 8;
  localparam int unsigned ASC_WARM_US = 220;
  localparam int unsigned ASC_WARM_CYCLES = (ASC_WARM_US * 1000 + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
  localparam int unsigned ASC_WARM_W = 15;

  typedef enum logic [1:0] {
    ASC_SHUTDOWN,
    ASC_WARMUP,
    ASC_RUN
  } asc_state_t;

  // Status reported by the analog side
  typedef struct packed {
    logic pll_locked;
    logic ref_present;
  } asc_analog_t;

  // Controls toward the analog side
  typedef struct packed {
    logic osc_enable;
    logic pa_enable;
  } asc_power_t;
endpackage : asc_pkg

// ===== core/asc_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
module asc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : asc_sync

// ===== core/asc_top.sv
// Activity shutdown controller: inactivity timer, wake, amplifier gating, clock out.
//
// Functional notes
// - Shut down after 2^16 cycles without edges
// - Any data edge clears inactivity counter
// - Rising data edge in shutdown starts warm-up
// - Amplifier held off until PLL locked
// - Amplifier off when reference is lost
// - Clock output is crystal divided by sixteen
// - Clock output held low during shutdown
// - Clock output stable after start-up interval
// - Data level keys amplifier when locked
`timescale 1ns/1ps
module asc_top
  import asc_pkg::*;
#(
  parameter int unsigned EOC_CYCLES = ASC_EOC_CYCLES,
  parameter int unsigned WARM_CYCLES = ASC_WARM_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic data_in,
  input wire asc_analog_t analog_in,
  output asc_power_t power_ff,
  output logic amplifier_output,
  output logic buffered_clock_output,
  output logic shutdown_ff
);
  localparam logic [ASC_CNT_W-1:0] EOC_LAST = ASC_CNT_W'(EOC_CYCLES - 1);
  localparam logic [ASC_WARM_W-1:0] WARM_LAST = ASC_WARM_W'(WARM_CYCLES - 1);
  localparam logic [ASC_DIV_W-1:0] DIV_HALF = ASC_DIV_W'(ASC_CLK_DIV / 2 - 1);

  logic data_s;
  asc_analog_t analog_s;
  logic data_d_ff;
  logic data_edge;
  logic data_rise;
  asc_state_t state_ff;
  asc_state_t nxt_state;
  logic [ASC_CNT_W-1:0] idle_cnt_ff;
  logic [ASC_WARM_W-1:0] warm_cnt_ff;
  logic [ASC_DIV_W-1:0] div_cnt_ff;
  logic eoc_hit;
  logic warm_done;

  // Analog status is asynchronous to this clock as well
  asc_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({data_in, analog_in}),
    .sync_out({data_s, analog_s})
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_d_ff <= 1'b0;
    end else begin
      data_d_ff <= data_s;
    end
  end

  assign data_edge = data_s ^ data_d_ff;
  assign data_rise = data_s & ~data_d_ff;
  assign eoc_hit = (state_ff == ASC_RUN) && !data_edge && (idle_cnt_ff == EOC_LAST);
  assign warm_done = warm_cnt_ff == WARM_LAST;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ASC_SHUTDOWN: begin
        if (data_rise) begin
          nxt_state = ASC_WARMUP;
        end
      end
      ASC_WARMUP: begin
        if (warm_done) begin
          nxt_state = ASC_RUN;
        end
      end
      ASC_RUN: begin
        if (eoc_hit) begin
          nxt_state = ASC_SHUTDOWN;
        end
      end
    endcase
  end

  // Reset leaves the device asleep so a first rising edge is needed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= ASC_SHUTDOWN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Edges during warm-up also restart the timer; it only runs in RUN
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idle_cnt_ff <= '0;
    end else if (state_ff != ASC_RUN || data_edge) begin
      idle_cnt_ff <= '0;
    end else if (idle_cnt_ff != EOC_LAST) begin
      idle_cnt_ff <= idle_cnt_ff + 1'b1;
    end
  end

  // Models oscillator start-up; the driver must honour it too
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      warm_cnt_ff <= '0;
    end else if (state_ff == ASC_WARMUP && !warm_done) begin
      warm_cnt_ff <= warm_cnt_ff + 1'b1;
    end else begin
      warm_cnt_ff <= '0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_cnt_ff <= '0;
      buffered_clock_output <= 1'b0;
    end else if (state_ff != ASC_RUN) begin
      div_cnt_ff <= '0;
      buffered_clock_output <= 1'b0;
    end else if (div_cnt_ff == DIV_HALF) begin
      div_cnt_ff <= '0;
      buffered_clock_output <= ~buffered_clock_output;
    end else begin
      div_cnt_ff <= div_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_ff <= '0;
      amplifier_output <= 1'b0;
      shutdown_ff <= 1'b1;
    end else begin
      power_ff.osc_enable <= nxt_state != ASC_SHUTDOWN;
      power_ff.pa_enable <= (state_ff == ASC_RUN) && analog_s.pll_locked && analog_s.ref_present;
      amplifier_output <= (state_ff == ASC_RUN) && analog_s.pll_locked && analog_s.ref_present && data_s;
      shutdown_ff <= nxt_state == ASC_SHUTDOWN;
    end
  end

  // Checker helper: cycles since the last clock output rise. Counting here
  // keeps the period check free of a long repetition.
  localparam logic [ASC_DIV_W-1:0] GAP_LAST = ASC_DIV_W'(ASC_CLK_DIV - 1);
  logic clk_out_d_ff;
  logic clk_rise;
  logic clk_seen_ff;
  logic [ASC_DIV_W-1:0] clk_gap_ff;

  assign clk_rise = buffered_clock_output & ~clk_out_d_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clk_out_d_ff <= 1'b0;
    end else begin
      clk_out_d_ff <= buffered_clock_output;
    end
  end

  // First rise after entering RUN only arms the check
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clk_seen_ff <= 1'b0;
      clk_gap_ff <= '0;
    end else if (state_ff != ASC_RUN) begin
      clk_seen_ff <= 1'b0;
      clk_gap_ff <= '0;
    end else if (clk_rise) begin
      clk_seen_ff <= 1'b1;
      clk_gap_ff <= '0;
    end else if (clk_gap_ff != GAP_LAST) begin
      clk_gap_ff <= clk_gap_ff + 1'b1;
    end
  end

  sequence idle_run_s;
    state_ff == ASC_RUN && !data_edge;
  endsequence

  sequence at_eoc_s;
    idle_run_s ##0 idle_cnt_ff == EOC_LAST;
  endsequence

  eoc_shutdown_a: assert property (@(posedge clock) disable iff (rst) at_eoc_s |=> state_ff == ASC_SHUTDOWN)
    else $error("no shutdown at end of count");
  edge_clears_a: assert property (@(posedge clock) disable iff (rst) data_edge |=> idle_cnt_ff == '0)
    else $error("edge did not clear counter");
  rise_wakes_a: assert property (@(posedge clock) disable iff (rst)
    state_ff == ASC_SHUTDOWN && data_rise |=> state_ff == ASC_WARMUP ##0 power_ff.osc_enable)
    else $error("rising edge did not wake");
  lock_gates_pa_a: assert property (@(posedge clock) disable iff (rst) !analog_s.pll_locked |=> !amplifier_output)
    else $error("amplifier on without lock");
  ref_gates_pa_a: assert property (@(posedge clock) disable iff (rst) !analog_s.ref_present |=> !power_ff.pa_enable)
    else $error("amplifier on without reference");
  sequence clk_rise_run_s;
    state_ff == ASC_RUN && clk_seen_ff && clk_rise;
  endsequence

  clk_period_a: assert property (@(posedge clock) disable iff (rst) clk_rise_run_s |-> clk_gap_ff == GAP_LAST)
    else $error("clock output period not sixteen");
  clk_steady_a: assert property (@(posedge clock) disable iff (rst)
    state_ff == ASC_RUN && clk_seen_ff && clk_gap_ff == GAP_LAST |-> clk_rise)
    else $error("clock output rise missing");
  clk_quiet_a: assert property (@(posedge clock) disable iff (rst)
    state_ff == ASC_SHUTDOWN |=> !buffered_clock_output)
    else $error("clock output active in shutdown");
  warm_len_a: assert property (@(posedge clock) disable iff (rst)
    state_ff == ASC_WARMUP && !warm_done |=> state_ff == ASC_WARMUP)
    else $error("warm-up ended early");
  warm_end_a: assert property (@(posedge clock) disable iff (rst)
    state_ff == ASC_WARMUP && warm_done |=> state_ff == ASC_RUN)
    else $error("warm-up did not end");
  wake_zero_a: assert property (@(posedge clock) disable iff (rst)
    $rose(state_ff == ASC_RUN) |-> idle_cnt_ff == '0)
    else $error("counter not zero on wake");
  keying_a: assert property (@(posedge clock) disable iff (rst)
    state_ff == ASC_RUN && analog_s.pll_locked && analog_s.ref_present && data_s |=> amplifier_output)
    else $error("data high did not key amplifier");
endmodule : asc_top

// ===== dv/activity_shutdown_controller_tb_top.sv
// Testbench for the activity shutdown controller.
`timescale 1ns/1ps
module activity_shutdown_controller_tb_top;
  import asc_pkg::*;
  localparam int EOC = 64;
  localparam int WARM = 16;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic key = 1'b0;
  asc_analog_t analog_in = '0;
  logic data_in;
  asc_power_t power_ff;
  logic amplifier_output;
  logic buffered_clock_output;
  logic shutdown_ff;
  int errors = 0;
  int n_compared = 0;

  always #4 clock = ~clock;

  asc_mcu_model mcu (.clock(clock), .key(key), .data_out(data_in));
  asc_top #(.EOC_CYCLES(EOC), .WARM_CYCLES(WARM)) uut (
    .clock(clock),
    .rst(rst),
    .data_in(data_in),
    .analog_in(analog_in),
    .power_ff(power_ff),
    .amplifier_output(amplifier_output),
    .buffered_clock_output(buffered_clock_output),
    .shutdown_ff(shutdown_ff)
  );

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Sample one step after the edge so its updates have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_cyc

  task automatic drive(input logic [2:0] v);
    @(posedge clock);
    key <= v[2];
    analog_in <= v[1:0];
    wait_cyc(6);
  endtask : drive

  task automatic t_wake();
    chk("shutdown", 8'h01, {7'h00, shutdown_ff});
    chk("clock_out", 8'h00, {7'h00, buffered_clock_output});
    drive(3'b100);
    wait_cyc(2);
    chk("shutdown", 8'h00, {7'h00, shutdown_ff});
    chk("osc_enable", 8'h01, {7'h00, power_ff.osc_enable});
    wait_cyc(WARM + 4);
    wait_cyc(EOC - 16);
    chk("shutdown", 8'h00, {7'h00, shutdown_ff});
  endtask : t_wake

  task automatic t_keying();
    logic [2:0] tbl [4] = '{3'b011, 3'b111, 3'b101, 3'b110};
    for (int i = 0; i < 4; i++) begin
      drive(tbl[i]);
      chk("amplifier", {7'h00, &tbl[i]}, {7'h00, amplifier_output});
      chk("pa_enable", {7'h00, &tbl[i][1:0]}, {7'h00, power_ff.pa_enable});
    end
  endtask : t_keying

  task automatic t_clkdiv();
    int n;
    n = 0;
    // Data stays high so this step adds no edge
    drive(3'b111);
    // Align to a fresh rise so the first high phase is counted whole
    while (buffered_clock_output !== 1'b0 && n < 40) begin
      wait_cyc(1);
      n++;
    end
    n = 0;
    while (buffered_clock_output !== 1'b1 && n < 40) begin
      wait_cyc(1);
      n++;
    end
    n = 0;
    while (buffered_clock_output === 1'b1 && n < 40) begin
      wait_cyc(1);
      n++;
    end
    chk("clock_out_high", 8'(ASC_CLK_DIV / 2), n[7:0]);
    n = 0;
    while (buffered_clock_output === 1'b0 && n < 40) begin
      wait_cyc(1);
      n++;
    end
    chk("clock_out_low", 8'(ASC_CLK_DIV / 2), n[7:0]);
  endtask : t_clkdiv

  task automatic t_idle();
    // Each gap is below the end-of-count, together far above it
    for (int i = 0; i < 4; i++) begin
      drive({i[0], 2'b11});
      wait_cyc(40);
      chk("shutdown", 8'h00, {7'h00, shutdown_ff});
    end
    // Last edge was taken 42 cycles ago: one cycle before and at end-of-count
    wait_cyc(EOC - 43);
    chk("shutdown", 8'h00, {7'h00, shutdown_ff});
    wait_cyc(1);
    chk("shutdown", 8'h01, {7'h00, shutdown_ff});
    // Clock and amplifier follow the state one cycle later
    wait_cyc(1);
    chk("clock_out", 8'h00, {7'h00, buffered_clock_output});
    chk("pa_enable", 8'h00, {7'h00, power_ff.pa_enable});
    // Data was left high, so this is a falling edge; it must not wake
    drive(3'b011);
    wait_cyc(2);
    chk("shutdown", 8'h01, {7'h00, shutdown_ff});
  endtask : t_idle

  task automatic print_verdict();
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  initial begin
    #(8 * 3000);
    errors++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    wait_cyc(1);
    t_wake();
    t_keying();
    t_clkdiv();
    t_idle();
    print_verdict();
  end
endmodule : activity_shutdown_controller_tb_top

// ===== dv/asc_mcu_model.sv
// Driving party model: puts the requested data level on the pin.
`timescale 1ns/1ps
module asc_mcu_model (
  input wire logic clock,
  input wire logic key,
  output logic data_out
);
  // Pin follows the request one edge later, low at start
  initial data_out = 1'b0;
  always @(posedge clock) begin
    data_out <= key;
  end
endmodule : asc_mcu_model
